// ===== core/rpc_pkg.sv
// Package: register map, field positions and timing constants of the regulator control block
package rpc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] REG_CTRL_OFS = 12'h000;
  localparam logic [11:0] REG_STAT_OFS = 12'h004;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hdb;

  // ****************************************
  // Field positions of regulator_control
  // ****************************************
  localparam int BIT_MAIN_DISABLE = 7;
  localparam int BIT_VBUS_STATUS = 6;
  localparam int BIT_RSVD_HI = 5;
  localparam int BIT_MAIN_LOWPOWER = 4;
  localparam int BIT_STOP_SHUTDOWN = 3;
  localparam int BIT_RSVD_LO = 2;
  localparam int BIT_CORE_LOWPOWER = 1;
  localparam int BIT_MPC_EN = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int WAKE_SKIP_CLOCKS = 20;
  localparam int MPC_MAX_FREQ_KHZ = 2000;
  localparam int PCLK_FREQ_KHZ = 20000;

  // Memory power sequencer states
  typedef enum logic [1:0] {
    RPC_MEM_ON = 2'b00,
    RPC_MEM_OFF = 2'b01,
    RPC_MEM_WAKE = 2'b10
  } rpc_mem_state_t;

endpackage

// ===== core/rpc_mem_power.sv
// Program memory power gating sequencer
`timescale 1ns/10ps
module rpc_mem_power #(
  parameter int SKIP_CLOCKS = rpc_pkg::WAKE_SKIP_CLOCKS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic gate_en,
  input wire logic fetch_req,
  input wire logic fast_clk,
  // Status
  output logic mem_power_on,
  output logic fetch_stall
);

  rpc_pkg::rpc_mem_state_t state_r;
  logic [4:0] cnt_r;
  logic fast_seen_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fast_seen_r <= 1'b0;
    else
      fast_seen_r <= fast_clk;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= rpc_pkg::RPC_MEM_ON;
      cnt_r <= 5'h00;
    end
    else
    begin
      case (state_r)
        rpc_pkg::RPC_MEM_ON:
        begin
          if (gate_en && !fetch_req)
            state_r <= rpc_pkg::RPC_MEM_OFF;
        end
        rpc_pkg::RPC_MEM_OFF:
        begin
          if (!gate_en)
            state_r <= rpc_pkg::RPC_MEM_ON;
          else if (fetch_req && fast_clk && !fast_seen_r)
          begin
            // Clock just sped up: wait for memory supply to settle
            state_r <= rpc_pkg::RPC_MEM_WAKE;
            cnt_r <= 5'(SKIP_CLOCKS - 1);
          end
          else if (fetch_req)
            state_r <= rpc_pkg::RPC_MEM_ON;
        end
        rpc_pkg::RPC_MEM_WAKE:
        begin
          if (cnt_r == 5'h00)
            state_r <= rpc_pkg::RPC_MEM_ON;
          else
            cnt_r <= cnt_r - 5'h01;
        end
        default:
          state_r <= rpc_pkg::RPC_MEM_ON;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_power_on <= 1'b1;
      fetch_stall <= 1'b0;
    end
    else
    begin
      mem_power_on <= !(state_r == rpc_pkg::RPC_MEM_OFF && !fetch_req && gate_en);
      fetch_stall <= (state_r == rpc_pkg::RPC_MEM_WAKE) ||
                     (state_r == rpc_pkg::RPC_MEM_OFF && fetch_req);
    end
  end

endmodule // rpc_mem_power

// ===== core/rpc_regulator_ctrl.sv
// Regulator power control block with APB register slave
//
// Contract
// - main_reg_lowpower set puts main regulator suspend
// - stop_reg_shutdown clear keeps core regulator, all resets
// - stop_reg_shutdown set: core off, pin reset only
// - core_reg_lowpower set puts core regulator low-power
// - gated program memory off when no fetch
// - prefetch enabled overrides memory power gating
// - gating disabled keeps program memory always powered
// - slow-to-fast clock change skips up to twenty clocks
// - main_reg_disable one disables main regulator
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module rpc_regulator_ctrl #(
  parameter int SKIP_CLOCKS = rpc_pkg::WAKE_SKIP_CLOCKS
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System status
  input wire logic vbus_present,
  input wire logic stop_mode,
  input wire logic prefetch_en,
  input wire logic fetch_req,
  input wire logic fast_clk,
  // Reset source requests
  input wire logic pin_reset_req,
  input wire logic other_reset_req,
  // Regulator controls
  output logic main_reg_enable,
  output logic main_reg_suspend,
  output logic core_reg_on,
  output logic core_reg_lowpower_mode,
  output logic sys_reset_req,
  // Program memory power
  output logic mem_power_on,
  output logic fetch_stall
);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] ctrl_r;
  logic vbus_r;
  logic core_shut_r;
  logic [1:0] stat_r;
  logic setup;
  logic hit_ctrl;
  logic hit_stat;
  logic wr_ctrl;
  logic [31:0] rdata_nxt;

  // ****************************************
  // Bus decode
  // ****************************************
  // Full compare: an alias would hide a firmware addressing slip
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a == ofs);
  endfunction

  assign setup = psel && !penable;
  assign hit_ctrl = addr_is(paddr, rpc_pkg::REG_CTRL_OFS);
  assign hit_stat = addr_is(paddr, rpc_pkg::REG_STAT_OFS);
  // Access phase is always one cycle long, so penable alone marks the landing edge
  assign wr_ctrl = psel && penable && pwrite && hit_ctrl;

  // Supply flag registered once; it only feeds the read path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vbus_r <= 1'b0;
    else
      vbus_r <= vbus_present;
  end

  // Bit 6 stores writes but nothing uses the stored value: reads show the registered supply flag vbus_r
  // Reserved bits store as zero regardless of firmware writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= rpc_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_r <= pwdata[7:0] & rpc_pkg::CTRL_WMASK;
  end

  // Read word built during setup so that prdata stands with pready
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (setup && !pwrite)
    begin
      if (hit_ctrl)
        rdata_nxt = {24'h00_0000, ctrl_r[7], vbus_r, ctrl_r[5:0]};
      else if (hit_stat)
        rdata_nxt = {30'h0000_0000, stat_r};
    end
  end

  // No wait state: answer on the first access cycle
  // Unmapped reads return zero with pslverr; unmapped writes change nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !(hit_ctrl || hit_stat);
      prdata <= rdata_nxt;
    end
  end

  // ****************************************
  // Regulator controls
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_reg_enable <= 1'b1;
      main_reg_suspend <= 1'b0;
      core_reg_lowpower_mode <= 1'b0;
    end
    else
    begin
      // Registered so a bus write never glitches a regulator control
      main_reg_enable <= !ctrl_r[rpc_pkg::BIT_MAIN_DISABLE];
      main_reg_suspend <= ctrl_r[rpc_pkg::BIT_MAIN_LOWPOWER];
      // Not guarded against a disabled main regulator; firmware must avoid it
      core_reg_lowpower_mode <= ctrl_r[rpc_pkg::BIT_CORE_LOWPOWER];
    end
  end

  // ****************************************
  // Stop mode and reset sources
  // ****************************************
  logic core_off_w;
  logic soft_reset_ok_w;

  // Shutdown latched during stop, so a later write cannot revive it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_shut_r <= 1'b0;
    else if (!stop_mode)
      core_shut_r <= 1'b0;
    else if (ctrl_r[rpc_pkg::BIT_STOP_SHUTDOWN])
      core_shut_r <= 1'b1;
  end

  // Regulator drops on the stop cycle itself, before the latch catches up
  assign core_off_w = core_shut_r || (stop_mode && ctrl_r[rpc_pkg::BIT_STOP_SHUTDOWN]);
  // Only the pin reaches the core from the cycle after its supply is gone
  assign soft_reset_ok_w = !core_shut_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_reg_on <= 1'b1;
      sys_reset_req <= 1'b0;
    end
    else
    begin
      core_reg_on <= !core_off_w;
      sys_reset_req <= pin_reset_req || (other_reset_req && soft_reset_ok_w);
    end
  end

  // ****************************************
  // Program memory power
  // ****************************************
  logic gate_en;
  logic mem_on_w;
  logic stall_w;

  // Prefetch engine owns the fetch timing, so gating is forced off
  assign gate_en = ctrl_r[rpc_pkg::BIT_MPC_EN] && !prefetch_en;

  // Sequencer outputs are its own registers, so the pins stay flop-driven
  rpc_mem_power #(
    .SKIP_CLOCKS(SKIP_CLOCKS)
  ) u_mem_power (
    .pclk(pclk),
    .presetn(presetn),
    .gate_en(gate_en),
    .fetch_req(fetch_req),
    .fast_clk(fast_clk),
    .mem_power_on(mem_on_w),
    .fetch_stall(stall_w)
  );

  assign mem_power_on = mem_on_w;
  assign fetch_stall = stall_w;

  // ****************************************
  // Status
  // ****************************************
  // Snapshot one cycle behind its sources; read-only over the bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_r <= 2'b00;
    else
      stat_r <= {core_shut_r, mem_on_w};
  end

endmodule // rpc_regulator_ctrl

// ===== tb/rpc_monitor.sv
// Assertion checker for the regulator control block
`timescale 1ns/10ps
module rpc_monitor #(
  parameter int SKIP_CLOCKS = 20
) (
  // Clock, reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Regulators
  input wire logic pin_reset_req,
  input wire logic main_reg_enable,
  input wire logic main_reg_suspend,
  input wire logic core_reg_lowpower_mode,
  input wire logic sys_reset_req,
  input wire logic fetch_stall
);
  localparam int STALL_MAX = SKIP_CLOCKS + 1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel && penable && pready && pwrite && paddr == 12'h000;
  // ****************
  // Properties
  // ****************
  a_ready_one_cycle: assert property (psel && !penable |=> pready)
    else $error("pready late");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
    else $error("pslverr wrong");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  // Two cycles covers a registered output stage too
  a_main_disable: assert property (wr |-> ##2 main_reg_enable == !$past(pwdata[7], 2))
    else $error("main enable wrong");
  a_main_suspend: assert property (wr |-> ##2 main_reg_suspend == $past(pwdata[4], 2))
    else $error("main suspend wrong");
  a_core_lowpower: assert property (wr |-> ##2 core_reg_lowpower_mode == $past(pwdata[1], 2))
    else $error("core mode wrong");
  a_pin_reset: assert property (pin_reset_req |=> sys_reset_req)
    else $error("pin reset lost");
  a_stall_bound: assert property ($rose(fetch_stall) |-> ##[1:STALL_MAX] !fetch_stall)
    else $error("stall too long");
  c_wr: cover property (wr);
  c_err: cover property (pready && pslverr);
  c_stall: cover property ($rose(fetch_stall));
endmodule // rpc_monitor
bind rpc_regulator_ctrl rpc_monitor #(.SKIP_CLOCKS(SKIP_CLOCKS)) u_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_reset_req(pin_reset_req), .main_reg_enable(main_reg_enable),
  .main_reg_suspend(main_reg_suspend), .core_reg_lowpower_mode(core_reg_lowpower_mode),
  .sys_reset_req(sys_reset_req), .fetch_stall(fetch_stall));

// ===== tb/tb_top.sv
// Self-checking bench for the regulator control block
`timescale 1ns/10ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, vbus_present, stop_mode, prefetch_en;
  logic fetch_req, fast_clk, pin_reset_req, other_reset_req, pready, pslverr, err;
  logic main_reg_enable, main_reg_suspend, core_reg_on, core_reg_lowpower_mode;
  logic sys_reset_req, mem_power_on, fetch_stall;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fail_count, checks, cyc;
  localparam logic [11:0] C = rpc_pkg::REG_CTRL_OFS;
  rpc_regulator_ctrl #(.SKIP_CLOCKS(3)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vbus_present(vbus_present), .stop_mode(stop_mode),
    .prefetch_en(prefetch_en), .fetch_req(fetch_req), .fast_clk(fast_clk),
    .pin_reset_req(pin_reset_req), .other_reset_req(other_reset_req),
    .main_reg_enable(main_reg_enable), .main_reg_suspend(main_reg_suspend),
    .core_reg_on(core_reg_on), .core_reg_lowpower_mode(core_reg_lowpower_mode),
    .sys_reset_req(sys_reset_req), .mem_power_on(mem_power_on), .fetch_stall(fetch_stall));
  // ****************
  // Helpers
  // ****************
  task automatic report_and_stop();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask
  // Falling edges: outputs are settled there; drives wait for a rising edge
  task automatic tick(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // Request held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    apb(C, 1'b0, 0);
    chk(rd, {24'h0, rpc_pkg::CTRL_RESET | 8'h40});
    apb(C, 1'b1, 32'h90);
    tick(2);
    chk(main_reg_enable, 1'b0);
    chk(main_reg_suspend, 1'b1);
    chk(core_reg_lowpower_mode, 1'b0);
    apb(C, 1'b0, 0);
    chk(rd, 32'hd0);
    apb(C, 1'b1, 32'h12);
    tick(2);
    chk({main_reg_enable, core_reg_lowpower_mode}, 2'b11);
    tick(12);
    apb(12'h008, 1'b0, 0);
    chk({rd[31:1], err}, 32'h1);
    apb(C, 1'b1, 0);
    tick(2);
    chk({main_reg_enable, main_reg_suspend, core_reg_lowpower_mode}, 3'b100);
    $display("t_regs done");
  endtask
  task automatic t_stop();
    @(posedge pclk);
    stop_mode <= 1'b1;
    other_reset_req <= 1'b1;
    tick(3);
    chk({core_reg_on, sys_reset_req}, 2'b11);
    apb(C, 1'b1, 32'h08);
    tick(3);
    chk({core_reg_on, sys_reset_req}, 2'b00);
    apb(rpc_pkg::REG_STAT_OFS, 1'b0, 0);
    chk(rd, 32'h3);
    @(posedge pclk);
    pin_reset_req <= 1'b1;
    tick(3);
    chk(sys_reset_req, 1'b1);
    @(posedge pclk);
    stop_mode <= 1'b0;
    pin_reset_req <= 1'b0;
    other_reset_req <= 1'b0;
    tick(4);
    chk(core_reg_on, 1'b1);
    $display("t_stop done");
  endtask
  task automatic t_mem();
    apb(C, 1'b1, 32'h01);
    tick(4);
    chk(mem_power_on, 1'b0);
    @(posedge pclk);
    fetch_req <= 1'b1;
    fast_clk <= 1'b1;
    // Fourth cycle of the fetch: only the wake wait can still stall here
    tick(4);
    chk(fetch_stall, 1'b1);
    tick(3);
    chk({fetch_stall, mem_power_on}, 2'b01);
    @(posedge pclk);
    fetch_req <= 1'b0;
    prefetch_en <= 1'b1;
    tick(6);
    chk(mem_power_on, 1'b1);
    @(posedge pclk);
    prefetch_en <= 1'b0;
    apb(C, 1'b1, 0);
    tick(6);
    chk(mem_power_on, 1'b1);
    $display("t_mem done");
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, stop_mode, prefetch_en, fetch_req} = 7'h00;
    {fast_clk, pin_reset_req, other_reset_req, paddr, pwdata} = 0;
    vbus_present = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_stop();
    t_mem();
    report_and_stop();
  end
endmodule // tb_top
